// ===== bench/mtw_master_model.sv
// Bus master model that clocks the two-wire slave.
`timescale 1ns/1ps
module mtw_master_model #(
  parameter int T = 24
) (
  input wire logic clk_sys,
  input wire logic sda_oe,
  output logic scl,
  output logic sda
);
  logic sda_m;
  // The wire has a pull-up, so a released line reads high.
  assign sda = sda_m && !sda_oe;
  initial begin
    scl = 1'b1;
    sda_m = 1'b1;
  end
  task automatic wt(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : wt
  // Waits out the slave's release before raising the clock line.
  task automatic start();
    sda_m = 1'b1;
    wt(12);
    scl = 1'b1;
    wt(T);
    sda_m = 1'b0;
    wt(T);
    scl = 1'b0;
  endtask : start
  task automatic stop();
    wt(4);
    sda_m = 1'b0;
    wt(T);
    scl = 1'b1;
    wt(T);
    sda_m = 1'b1;
    wt(T);
  endtask : stop
  task automatic bit_x(input logic b, output logic r);
    wt(4);
    sda_m = b;
    wt(T);
    scl = 1'b1;
    wt(T / 2);
    r = sda;
    wt(T / 2);
    scl = 1'b0;
  endtask : bit_x
  task automatic byte_x(input logic [7:0] d, input logic m,
                        output logic [7:0] q, output logic a);
    for (int i = 7; i >= 0; i--) bit_x(d[i], q[i]);
    bit_x(m, a);
  endtask : byte_x
endmodule : mtw_master_model

// ===== bench/mtw_monitor.sv
// Checker watching the two-wire slave ports.
`timescale 1ns/1ps
module mtw_monitor
  import mtw_pkg::*;
#(
  parameter int unsigned TIMEOUT_CYC = TIMEOUT_CYCLES
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_oe,
  input wire logic [15:0] cfg1_word,
  input wire logic [15:0] cfg2_word,
  input wire logic [2:0] volt_mode,
  input wire logic volt_stop_now,
  input wire logic volt_stop_at_end,
  input wire logic [4:0] temp_enable,
  input wire logic temp_stop_now,
  input wire logic temp_stop_at_end,
  input wire logic conv_abort,
  input wire logic [15:0] status_mask,
  input wire logic alert_enable,
  input wire logic wdog_active_high,
  input wire logic wdog_latched,
  input wire logic hs_mode
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  logic scl_q;
  logic sda_q;
  logic [7:0] fall_cnt;
  logic [7:0] stop_cnt;
  int unsigned idle_cnt;
  always_ff @(posedge clk_sys) begin
    scl_q <= scl_in;
    sda_q <= sda_in;
  end
  always_ff @(posedge clk_sys) begin
    if (reset) fall_cnt <= 8'hff;
    else if (scl_q && !scl_in) fall_cnt <= 8'h00;
    else if (fall_cnt != 8'hff) fall_cnt <= fall_cnt + 8'h01;
  end
  always_ff @(posedge clk_sys) begin
    if (reset) stop_cnt <= 8'hff;
    else if (scl_in && scl_q && sda_in && !sda_q) stop_cnt <= 8'h00;
    else if (stop_cnt != 8'hff) stop_cnt <= stop_cnt + 8'h01;
  end
  // Pin-side count; the design's own count starts a few cycles later.
  always_ff @(posedge clk_sys) begin
    if (reset || scl_in != scl_q) idle_cnt <= 0;
    else idle_cnt <= idle_cnt + 1;
  end
  sequence s_scl_rise;
    $rose(scl_in);
  endsequence
  sequence s_oe_rise;
    $rose(sda_oe);
  endsequence
  a_ack_hold: assert property (s_scl_rise |-> ##4 $stable(sda_oe) [*8])
    else $error("sda_oe moved while scl high");
  a_drive_timing: assert property (s_oe_rise |-> fall_cnt <= 8'd12)
    else $error("sda_oe rose away from an scl fall");
  a_bus_timeout: assert property (sda_oe |-> idle_cnt <= TIMEOUT_CYC + 32)
    else $error("sda_oe held past the bus timeout");
  a_hs_exit: assert property ($fell(hs_mode) |-> stop_cnt <= 8'd12)
    else $error("hs_mode left without a stop");
  a_reset_defaults: assert property ($past(reset) |->
    status_mask == MASK_RESET && !alert_enable && !wdog_active_high
    && !wdog_latched) else $error("bad values after reset");
  a_soft_reset: assert property (conv_abort |-> ##[0:4]
    (status_mask == MASK_RESET && cfg2_word == CFG2_RESET))
    else $error("soft reset left registers set");
  a_volt_now: assert property (volt_stop_now |-> ##[0:2]
    volt_mode == MODE_STOP_NOW) else $error("volt stop now wrong");
  a_volt_end: assert property (volt_stop_at_end |-> ##[0:2]
    volt_mode == MODE_STOP_AT_END) else $error("volt stop end wrong");
  a_temp_now: assert property (temp_stop_now |-> ##[0:2]
    temp_enable == TEMP_ALL_OFF) else $error("temp stop now wrong");
  a_temp_end: assert property (temp_stop_at_end |-> ##[0:2]
    (!temp_enable[4] && temp_enable != TEMP_ALL_OFF))
    else $error("temp stop end wrong");
endmodule : mtw_monitor
bind mtw_slave mtw_monitor #(.TIMEOUT_CYC(TIMEOUT_CYC)) u_mtw_monitor (
  .clk_sys(clk_sys), .reset(reset), .scl_in(scl_in), .sda_in(sda_in),
  .sda_oe(sda_oe), .cfg1_word(cfg1_word), .cfg2_word(cfg2_word),
  .volt_mode(volt_mode), .volt_stop_now(volt_stop_now),
  .volt_stop_at_end(volt_stop_at_end), .temp_enable(temp_enable),
  .temp_stop_now(temp_stop_now), .temp_stop_at_end(temp_stop_at_end),
  .conv_abort(conv_abort), .status_mask(status_mask),
  .alert_enable(alert_enable), .wdog_active_high(wdog_active_high),
  .wdog_latched(wdog_latched), .hs_mode(hs_mode));

// ===== bench/tb_mtw_slave.sv
// Self-checking bench for the two-wire slave.
`timescale 1ns/1ps
module tb_mtw_slave;
  import mtw_pkg::*;
  localparam int unsigned TO_CYC = 2000;
  localparam logic [6:0] BASE = 7'h5c;
  logic clk_sys, reset, scl, sda, sda_oe, asel_pin, ak, b, hs_mode, so;
  logic [1:0] asel;
  logic [6:0] dev;
  logic [7:0] r8, hi;
  logic [4:0] seen, temp_enable;
  logic [2:0] volt_mode;
  logic [15:0] cfg1_word, cfg2_word, status_mask;
  logic vsn, vse, tsn, tse, abort, alert, wah, wl, seen_clr;
  int mismatches, tests_run;
  assign asel_pin = (asel == SEL_SDA) ? sda :
                    (asel == SEL_SCL) ? scl : asel[0];
  always @(posedge clk_sys)
    seen <= seen_clr ? 5'h00 : seen | {abort, tse, tsn, vse, vsn};
  mtw_slave #(.TIMEOUT_CYC(TO_CYC)) u_mtw_slave (
    .clk_sys(clk_sys), .reset(reset), .ce(1'b1), .scl_in(scl),
    .sda_in(sda), .sda_out(so), .sda_oe(sda_oe),
    .address_select_pin(asel_pin), .cfg1_word(cfg1_word),
    .cfg2_word(cfg2_word), .volt_mode(volt_mode), .volt_stop_now(vsn),
    .volt_stop_at_end(vse), .temp_enable(temp_enable),
    .temp_stop_now(tsn), .temp_stop_at_end(tse), .conv_abort(abort),
    .status_mask(status_mask), .alert_enable(alert),
    .wdog_active_high(wah), .wdog_latched(wl), .hs_mode(hs_mode));
  mtw_master_model u_mtw_master_model (.clk_sys(clk_sys),
    .sda_oe(sda_oe && !so), .scl(scl), .sda(sda));
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    tests_run++;
    if (s !== e) begin
      mismatches++;
      $display("[ERR] %0t seen %h expected %h", $time, s, e);
    end
  endtask : chk
  task automatic bt(input logic [7:0] d, input logic m);
    seen_clr = 1'b0;
    u_mtw_master_model.byte_x(d, m, r8, ak);
  endtask : bt
  task automatic probe(input logic e);
    u_mtw_master_model.start();
    bt({dev, 1'b0}, 1'b1);
    chk(16'(ak), 16'(e));
    u_mtw_master_model.stop();
  endtask : probe
  task automatic wr(input logic [7:0] p, input logic w, input logic [15:0] d);
    u_mtw_master_model.start();
    bt({dev, 1'b0}, 1'b1);
    chk(16'(ak), 16'h0);
    bt(p, 1'b1);
    chk(16'(ak), 16'h0);
    if (w) begin
      bt(d[15:8], 1'b1);
      chk(16'(ak), 16'h0);
      bt(d[7:0], 1'b1);
      chk(16'(ak), 16'h0);
    end
    u_mtw_master_model.stop();
  endtask : wr
  task automatic rd(input logic [15:0] e);
    u_mtw_master_model.start();
    bt({dev, 1'b1}, 1'b1);
    chk(16'(ak), 16'h0);
    bt(8'hff, 1'b0);
    hi = r8;
    bt(8'hff, 1'b1);
    chk({hi, r8}, e);
    u_mtw_master_model.stop();
    chk(16'(sda_oe), 16'h0);
  endtask : rd
  task automatic gc(input logic [7:0] c);
    u_mtw_master_model.start();
    bt(GC_ADDR, 1'b1);
    chk(16'(ak), 16'h0);
    bt(c, 1'b1);
    chk(16'(ak), 16'h0);
    u_mtw_master_model.stop();
  endtask : gc
  task automatic t_reset();
    chk(cfg1_word, CFG1_RESET);
    chk(cfg2_word, CFG2_RESET);
    chk(status_mask, MASK_RESET);
    chk({13'h0, wl, wah, alert}, 16'h0);
    rd(CFG1_RESET);
  endtask : t_reset
  task automatic t_addr();
    for (int i = 0; i < 4; i++) begin
      asel = 2'(i);
      dev = BASE + 7'(i ^ 1);
      probe(1'b1);
      dev = BASE + 7'(i);
      probe(1'b0);
    end
  endtask : t_addr
  task automatic t_rw();
    wr(8'h10, 1'b1, 16'ha5c3);
    wr(PTR_MASK, 1'b1, 16'h1234);
    chk(status_mask, 16'h1234);
    wr(8'h10, 1'b0, 16'h0000);
    rd(16'ha5c3);
    rd(16'ha5c3);
  endtask : t_rw
  task automatic t_modes();
    logic [7:0] p [4] = '{PTR_CFG1, PTR_CFG1, PTR_CFG2, PTR_CFG2};
    logic [15:0] d [4] = '{16'h0000, 16'h0004, 16'h0000, 16'h7800};
    for (int i = 0; i < 4; i++) begin
      seen_clr = 1'b1;
      wr(p[i], 1'b1, d[i]);
      chk(16'(seen), 16'(5'h01 << i));
    end
    chk({8'h0, volt_mode, temp_enable}, 16'h008f);
  endtask : t_modes
  task automatic t_soft();
    wr(PTR_CTRL, 1'b1, 16'h0007);
    chk({13'h0, wl, wah, alert}, 16'h0007);
    seen_clr = 1'b1;
    wr(PTR_CFG1, 1'b1, 16'h8007);
    chk({cfg1_word[15], seen[4], wl, wah, alert}, 16'h08);
    chk(cfg2_word, CFG2_RESET);
    wr(PTR_MASK, 1'b1, 16'h00ff);
    gc(8'h07);
    chk(status_mask, 16'h00ff);
    gc(GC_RESET_CMD);
    chk(status_mask, MASK_RESET);
    rd(CFG1_RESET);
  endtask : t_soft
  task automatic t_hs();
    u_mtw_master_model.start();
    bt(8'h0d, 1'b1);
    chk({15'h0, ak}, 16'h1);
    chk(16'(hs_mode), 16'h1);
    rd(CFG1_RESET);
    chk(16'(hs_mode), 16'h0);
  endtask : t_hs
  task automatic t_timeout();
    u_mtw_master_model.start();
    for (int i = 7; i >= 0; i--) u_mtw_master_model.bit_x(i && dev[i - 1], b);
    u_mtw_master_model.wt(20);
    chk(16'(sda_oe), 16'h1);
    u_mtw_master_model.wt(TO_CYC + 40);
    chk(16'(sda_oe), 16'h0);
    u_mtw_master_model.stop();
    rd(CFG1_RESET);
  endtask : t_timeout
  task automatic report_and_stop();
    $display("mismatches %0d tests_run %0d", mismatches, tests_run);
    if (mismatches == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : report_and_stop
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  initial begin
    repeat (90000) @(posedge clk_sys);
    mismatches++;
    report_and_stop();
  end
  initial begin
    reset = 1'b1;
    asel = SEL_GND;
    dev = BASE;
    seen_clr = 1'b1;
    mismatches = 0;
    tests_run = 0;
    repeat (3) @(negedge clk_sys);
    reset = 1'b0;
    repeat (4) @(negedge clk_sys);
    t_reset();
    t_addr();
    t_rw();
    t_modes();
    t_soft();
    t_hs();
    t_timeout();
    report_and_stop();
  end
endmodule : tb_mtw_slave

// ===== design/mtw_reg_mem.sv
// Word store for the general registers behind the pointer.
`timescale 1ns/1ps
module mtw_reg_mem #(
  parameter int AW = 5,
  parameter int DW = 16
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic ce,
  mtw_mem_if.store mem
);
  localparam int DEPTH = 1 << AW;

  logic [DW-1:0] words [DEPTH];

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  // A flop array rather than a RAM, so a reset can clear every word.
  always_ff @(posedge clk_sys) begin
    if (reset || (ce && mem.clr)) begin
      for (int i = 0; i < DEPTH; i++) begin
        words[i] <= '0;
      end
    end else if (ce && mem.we) begin
      words[mem.waddr] <= mem.wdata;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      mem.rdata <= '0;
    end else if (ce) begin
      mem.rdata <= words[mem.raddr];
    end
  end
endmodule : mtw_reg_mem

// ===== design/mtw_slave.sv
// Two-wire slave access logic of the system monitor.
// Function
// - First byte after write address is pointer.
// - Acknowledge own configured slave address.
// - Load received pointer byte into pointer.
// - Next two bytes form word, MSB first.
// - Reads return register selected by pointer.
// - Pointer-only write updates the read target.
// - Transmit MSB, then LSB after master ack.
// - Release data line on NACK, START, STOP.
// - Pointer persists until a later write.
// - Detect START and STOP on data edges.
// - Master decides byte count; acknowledge each. General call: bytes after the command byte get no ACK.
// - Hold acknowledge low through ninth clock high.
// - Ignore high-speed code, switch to high-speed filters.
// - Leave high-speed operation on STOP.
// - Reset bit or general call 06h restores power-up.
// - Reset masks status bits, disables alert.
// - Reset makes watchdogs active-low and transparent.
// - Mode code 000 stops voltage measurement now.
// - Mode code 100 stops after current conversion.
// - Zero temperature enables stop temperature now.
// - Clearing bit 15 stops temperature after conversion.
// - Address select pin picks one of four.
// - Bus timeout resets the interface.
// - General call acknowledged; 06h resets everything.
// - Pointer holds zero after reset.
`timescale 1ns/1ps
module mtw_slave
  import mtw_pkg::*;
#(
  parameter int unsigned TIMEOUT_CYC = TIMEOUT_CYCLES,
  parameter int MEM_DEPTH = 32
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic ce,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic address_select_pin,
  output logic [15:0] cfg1_word,
  output logic [15:0] cfg2_word,
  output logic [2:0] volt_mode,
  output logic volt_stop_now,
  output logic volt_stop_at_end,
  output logic [4:0] temp_enable,
  output logic temp_stop_now,
  output logic temp_stop_at_end,
  output logic conv_abort,
  output logic [15:0] status_mask,
  output logic alert_enable,
  output logic wdog_active_high,
  output logic wdog_latched,
  output logic hs_mode
);
  localparam int AW = $clog2(MEM_DEPTH);
  localparam int TO_W = $clog2(TIMEOUT_CYC + 1);

  if (MEM_DEPTH < 2 || MEM_DEPTH > 128 ||
      (MEM_DEPTH & (MEM_DEPTH - 1)) != 0) begin : g_bad_depth
    $error("MEM_DEPTH must be a power of two from 2 to 128.");
  end
  if (TIMEOUT_CYC < 2) begin : g_bad_timeout
    $error("TIMEOUT_CYC must be at least 2.");
  end

  // ----------------------------------------------------------------
  // Pin synchronisers and spike filters
  // ----------------------------------------------------------------
  logic [1:0] pin_meta;
  logic [1:0] pin_sync;
  logic [1:0] pin_filt;
  logic asel_meta;
  logic asel_sync;
  logic [3:0] filt_len;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      pin_meta <= 2'h3;
      pin_sync <= 2'h3;
      asel_meta <= 1'b0;
      asel_sync <= 1'b0;
    end else if (ce) begin
      pin_meta <= {sda_in, scl_in};
      pin_sync <= pin_meta;
      asel_meta <= address_select_pin;
      asel_sync <= asel_meta;
    end
  end

  assign filt_len = hs_mode ? FILT_HS_CYC : FILT_FAST_CYC;

  for (genvar i = 0; i < 2; i++) begin : g_filt
    logic [3:0] cnt;
    logic level;
    always_ff @(posedge clk_sys) begin
      if (reset) begin
        cnt <= 4'h0;
        level <= 1'b1;
      end else if (ce) begin
        if (pin_sync[i] == level) begin
          cnt <= 4'h0;
        end else if (cnt >= filt_len) begin
          level <= pin_sync[i];
          cnt <= 4'h0;
        end else begin
          cnt <= cnt + 4'h1;
        end
      end
    end
    assign pin_filt[i] = level;
  end

  // ----------------------------------------------------------------
  // Bus events
  // ----------------------------------------------------------------
  logic scl;
  logic sda;
  logic scl_d;
  logic sda_d;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;

  assign scl = pin_filt[0];
  assign sda = pin_filt[1];

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else if (ce) begin
      scl_d <= scl;
      sda_d <= sda;
    end
  end

  assign scl_rise = scl && !scl_d;
  assign scl_fall = !scl && scl_d;
  assign start_det = scl && scl_d && sda_d && !sda;
  assign stop_det = scl && scl_d && !sda_d && sda;

  // ----------------------------------------------------------------
  // Protocol state
  // ----------------------------------------------------------------
  mtw_state_type state;
  mtw_role_type role;
  logic [3:0] bit_cnt;
  logic [7:0] rx_shift;
  logic [15:0] tx_shift;
  logic [15:0] next_tx;
  logic [7:0] msb_hold;
  logic [7:0] pointer;
  logic go_tx;
  logic first_byte;
  logic master_ack;
  logic bus_timeout;
  logic byte_end;
  logic [6:0] own_addr;
  logic [1:0] sel_code;
  logic sel_s1;
  logic sel_s2;
  logic sel_s3;
  logic is_hs;
  logic addr_hit;
  logic gc_hit;
  logic [15:0] rd_word;

  assign byte_end = scl_fall && state == ST_RX && bit_cnt == BITS_PER_BYTE;
  assign is_hs = first_byte && rx_shift[7:3] == HS_CODE_HI;
  assign addr_hit = rx_shift[7:1] == own_addr;
  assign gc_hit = rx_shift == GC_ADDR;
  assign next_tx = {tx_shift[14:0], tx_shift[15]};

  // The pin level is taken at START, at the first SCL fall and at the
  // first SCL rise; only that pattern tells a tie to SDA or SCL apart.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      sel_s1 <= 1'b0;
      sel_s2 <= 1'b0;
      sel_s3 <= 1'b0;
    end else if (ce) begin
      if (start_det) begin
        sel_s1 <= asel_sync;
      end
      if (state == ST_RX && first_byte && bit_cnt == 4'h0) begin
        if (scl_fall) begin
          sel_s2 <= asel_sync;
        end
        if (scl_rise) begin
          sel_s3 <= asel_sync;
        end
      end
    end
  end

  assign sel_code = sel_s1 ? (sel_s2 ? SEL_VPLUS : SEL_SCL)
                           : (sel_s3 ? SEL_SDA : SEL_GND);
  assign own_addr = {ADDR_BASE, sel_code};

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state <= ST_IDLE;
      role <= RL_ADDR;
      bit_cnt <= 4'h0;
      rx_shift <= 8'h00;
      tx_shift <= WORD_ZERO;
      msb_hold <= 8'h00;
      go_tx <= 1'b0;
      first_byte <= 1'b0;
      master_ack <= 1'b0;
      sda_oe <= 1'b0;
    end else if (ce) begin
      if (stop_det || bus_timeout) begin
        state <= ST_IDLE;
        sda_oe <= 1'b0;
      end else if (start_det) begin
        state <= ST_RX;
        role <= RL_ADDR;
        bit_cnt <= 4'h0;
        first_byte <= 1'b1;
        go_tx <= 1'b0;
        sda_oe <= 1'b0;
      end else begin
        unique case (state)
          ST_IDLE, ST_IGNORE: begin
            sda_oe <= 1'b0;
          end
          ST_RX: begin
            if (scl_rise) begin
              rx_shift <= {rx_shift[6:0], sda};
              bit_cnt <= bit_cnt + 4'h1;
            end else if (byte_end) begin
              first_byte <= 1'b0;
              state <= ST_RX_ACK;
              sda_oe <= 1'b1;
              unique case (role)
                RL_ADDR: begin
                  if (is_hs) begin
                    state <= ST_IGNORE;
                    sda_oe <= 1'b0;
                  end else if (addr_hit) begin
                    go_tx <= rx_shift[0];
                    role <= RL_PTR;
                    tx_shift <= rd_word;
                  end else if (gc_hit && !rx_shift[0]) begin
                    role <= RL_GC;
                  end else begin
                    state <= ST_IGNORE;
                    sda_oe <= 1'b0;
                  end
                end
                RL_PTR: role <= RL_MSB;
                RL_MSB: begin
                  msb_hold <= rx_shift;
                  role <= RL_LSB;
                end
                RL_LSB: role <= RL_MSB;
                RL_GC: role <= RL_DONE;
                RL_DONE: role <= RL_DONE;
                default: role <= RL_DONE;
              endcase
            end
          end
          ST_RX_ACK: begin
            if (scl_fall) begin
              bit_cnt <= 4'h0;
              if (go_tx) begin
                state <= ST_TX;
                sda_oe <= !tx_shift[15];
              end else begin
                state <= (role == RL_DONE) ? ST_IGNORE : ST_RX;
                sda_oe <= 1'b0;
              end
            end
          end
          ST_TX: begin
            if (scl_rise) begin
              bit_cnt <= bit_cnt + 4'h1;
            end else if (scl_fall) begin
              tx_shift <= next_tx;
              if (bit_cnt == BITS_PER_BYTE) begin
                state <= ST_TX_ACK;
                sda_oe <= 1'b0;
              end else begin
                sda_oe <= !next_tx[15];
              end
            end
          end
          ST_TX_ACK: begin
            if (scl_rise) begin
              master_ack <= !sda;
            end else if (scl_fall) begin
              bit_cnt <= 4'h0;
              if (master_ack) begin
                state <= ST_TX;
                sda_oe <= !tx_shift[15];
              end else begin
                state <= ST_IGNORE;
                sda_oe <= 1'b0;
              end
            end
          end
          default: begin
            state <= ST_IDLE;
            sda_oe <= 1'b0;
          end
        endcase
      end
    end
  end

  assign sda_out = 1'b0;

  // ----------------------------------------------------------------
  // Bus timeout and high-speed tracking
  // ----------------------------------------------------------------
  logic [TO_W-1:0] to_cnt;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      to_cnt <= '0;
    end else if (ce) begin
      if (state == ST_IDLE || scl_rise || scl_fall || start_det) begin
        to_cnt <= '0;
      end else if (!bus_timeout) begin
        to_cnt <= to_cnt + 1'b1;
      end else begin
        to_cnt <= '0;
      end
    end
  end

  assign bus_timeout = to_cnt == TO_W'(TIMEOUT_CYC - 1);

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      hs_mode <= 1'b0;
    end else if (ce) begin
      if (stop_det) begin
        hs_mode <= 1'b0;
      end else if (byte_end && role == RL_ADDR && is_hs) begin
        hs_mode <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Pointer and registers
  // ----------------------------------------------------------------
  logic wr_evt;
  logic ptr_evt;
  logic gc_evt;
  logic rst_evt;
  logic soft_rst;
  logic [15:0] wr_word;
  logic [15:0] ctrl_word;
  logic local_hit;
  logic mem_hit;

  mtw_mem_if #(.AW(AW), .DW(16)) mem_bus ();

  assign wr_word = {msb_hold, rx_shift};
  assign ptr_evt = byte_end && role == RL_PTR;
  assign wr_evt = byte_end && role == RL_LSB;
  assign gc_evt = byte_end && role == RL_GC &&
                  rx_shift == GC_RESET_CMD;
  assign rst_evt = gc_evt || (wr_evt && pointer == PTR_CFG1 &&
                   wr_word[CFG1_RST_BIT]);
  assign local_hit = pointer == PTR_CFG1 || pointer == PTR_CFG2 ||
                     pointer == PTR_MASK || pointer == PTR_CTRL;
  assign mem_hit = pointer < 8'(MEM_DEPTH) && !local_hit;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      soft_rst <= 1'b0;
    end else if (ce) begin
      soft_rst <= rst_evt;
    end
  end

  // The reset word is acted on one cycle later, after the ACK is set.
  always_ff @(posedge clk_sys) begin
    if (reset || (ce && soft_rst)) begin
      pointer <= PTR_RESET;
    end else if (ce && ptr_evt) begin
      pointer <= rx_shift;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset || (ce && soft_rst)) begin
      cfg1_word <= CFG1_RESET;
      cfg2_word <= CFG2_RESET;
      status_mask <= MASK_RESET;
      ctrl_word <= CTRL_RESET;
    end else if (ce && wr_evt) begin
      if (pointer == PTR_CFG1) begin
        cfg1_word <= wr_word;
      end
      if (pointer == PTR_CFG2) begin
        cfg2_word <= wr_word;
      end
      if (pointer == PTR_MASK) begin
        status_mask <= wr_word;
      end
      if (pointer == PTR_CTRL) begin
        ctrl_word <= wr_word;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      volt_stop_now <= 1'b0;
      volt_stop_at_end <= 1'b0;
      temp_stop_now <= 1'b0;
      temp_stop_at_end <= 1'b0;
      conv_abort <= 1'b0;
    end else if (ce) begin
      volt_stop_now <= wr_evt && pointer == PTR_CFG1 &&
        wr_word[MODE_MSB:MODE_LSB] == MODE_STOP_NOW;
      volt_stop_at_end <= wr_evt && pointer == PTR_CFG1 &&
        wr_word[MODE_MSB:MODE_LSB] == MODE_STOP_AT_END;
      temp_stop_now <= wr_evt && pointer == PTR_CFG2 &&
        wr_word[TEMP_EN_MSB:TEMP_EN_LSB] == TEMP_ALL_OFF;
      temp_stop_at_end <= wr_evt && pointer == PTR_CFG2 &&
        !wr_word[TEMP_EN_MSB] &&
        wr_word[TEMP_EN_MSB:TEMP_EN_LSB] != TEMP_ALL_OFF;
      conv_abort <= rst_evt;
    end
  end

  assign volt_mode = cfg1_word[MODE_MSB:MODE_LSB];
  assign temp_enable = cfg2_word[TEMP_EN_MSB:TEMP_EN_LSB];
  assign alert_enable = ctrl_word[CTRL_ALERT_BIT];
  assign wdog_active_high = ctrl_word[CTRL_POL_BIT];
  assign wdog_latched = ctrl_word[CTRL_LATCH_BIT];

  // Unmapped pointers read as zero and drop writes.
  always_comb begin
    rd_word = WORD_ZERO;
    if (pointer == PTR_CFG1) begin
      rd_word = cfg1_word;
    end else if (pointer == PTR_CFG2) begin
      rd_word = cfg2_word;
    end else if (pointer == PTR_MASK) begin
      rd_word = status_mask;
    end else if (pointer == PTR_CTRL) begin
      rd_word = ctrl_word;
    end else if (mem_hit) begin
      rd_word = mem_bus.rdata;
    end
  end

  assign mem_bus.we = wr_evt && mem_hit;
  assign mem_bus.waddr = pointer[AW-1:0];
  assign mem_bus.wdata = wr_word;
  assign mem_bus.raddr = pointer[AW-1:0];
  assign mem_bus.clr = soft_rst;

  mtw_reg_mem #(.AW(AW), .DW(16)) u_mem (
    .clk_sys(clk_sys),
    .reset(reset),
    .ce(ce),
    .mem(mem_bus.store)
  );
endmodule : mtw_slave

// ===== shared/mtw_mem_if.sv
// Interface joining the slave core to its register store.
`timescale 1ns/1ps
interface mtw_mem_if #(
  parameter int AW = 5,
  parameter int DW = 16
);
  logic we;
  logic [AW-1:0] waddr;
  logic [DW-1:0] wdata;
  logic [AW-1:0] raddr;
  logic [DW-1:0] rdata;
  logic clr;

  modport ctrl (output we, output waddr, output wdata, output raddr,
                output clr, input rdata);
  modport store (input we, input waddr, input wdata, input raddr,
                 input clr, output rdata);
endinterface : mtw_mem_if

// ===== shared/mtw_pkg.sv
// Constants, types and reset values shared by the two-wire slave files.
package mtw_pkg;

  // ----------------------------------------------------------------
  // Register pointers and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] PTR_CFG1 = 8'h00;
  localparam logic [7:0] PTR_CFG2 = 8'h01;
  localparam logic [7:0] PTR_MASK = 8'h03;
  localparam logic [7:0] PTR_CTRL = 8'h04;
  localparam logic [7:0] PTR_RESET = 8'h00;
  localparam logic [15:0] CFG1_RESET = 16'h0007;
  localparam logic [15:0] CFG2_RESET = 16'hf800;
  localparam logic [15:0] MASK_RESET = 16'hffff;
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic [15:0] WORD_ZERO = 16'h0000;

  // ----------------------------------------------------------------
  // Field positions and codes
  // ----------------------------------------------------------------
  localparam int CFG1_RST_BIT = 15;
  localparam int MODE_MSB = 2;
  localparam int MODE_LSB = 0;
  localparam logic [2:0] MODE_STOP_NOW = 3'h0;
  localparam logic [2:0] MODE_STOP_AT_END = 3'h4;
  localparam int TEMP_EN_MSB = 15;
  localparam int TEMP_EN_LSB = 11;
  localparam logic [4:0] TEMP_ALL_OFF = 5'h00;
  localparam int CTRL_ALERT_BIT = 0;
  localparam int CTRL_POL_BIT = 1;
  localparam int CTRL_LATCH_BIT = 2;
  localparam logic [4:0] ADDR_BASE = 5'h17;
  localparam logic [4:0] HS_CODE_HI = 5'h01;
  localparam logic [7:0] GC_ADDR = 8'h00;
  localparam logic [7:0] GC_RESET_CMD = 8'h06;
  localparam logic [1:0] SEL_GND = 2'h0;
  localparam logic [1:0] SEL_VPLUS = 2'h1;
  localparam logic [1:0] SEL_SDA = 2'h2;
  localparam logic [1:0] SEL_SCL = 2'h3;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned TIMEOUT_MS = 28;
  localparam longint unsigned CLK_HZ = 64'd125000000;
  localparam int unsigned TIMEOUT_CYCLES =
    int'((64'(TIMEOUT_MS) * CLK_HZ) / 64'd1000);
  localparam logic [3:0] FILT_FAST_CYC = 4'h4;
  localparam logic [3:0] FILT_HS_CYC = 4'h1;

  // ----------------------------------------------------------------
  // State encodings
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_RX = 3'b001,
    ST_RX_ACK = 3'b010,
    ST_TX = 3'b011,
    ST_TX_ACK = 3'b100,
    ST_IGNORE = 3'b101
  } mtw_state_type;

  typedef enum logic [2:0] {
    RL_ADDR = 3'b000,
    RL_PTR = 3'b001,
    RL_MSB = 3'b010,
    RL_LSB = 3'b011,
    RL_GC = 3'b100,
    RL_DONE = 3'b101
  } mtw_role_type;

endpackage : mtw_pkg
